// ===== design/pwm_timer_status_counter.sv
// Timer status/control, modulo and counter with an Avalon-MM slave
// Summary of operation
// - DMA enable set makes overflow flag raise a DMA request.
// - Overflow flag sets when counter equals modulo and then advances.
// - Writing one clears overflow flag; writing zero leaves it.
// - New overflow in the clearing cycle keeps flag set.
// - Interrupt enable passes overflow flag onto the interrupt line.
// - Center-aligned select: zero counts up, one counts up and down.
// - Center-aligned select and prescale accept writes only while disabled.
// - Clock mode 00 disabled, 01 every clock, 11 reserved.
// - Clock mode 10 counts synchronised external clock rising edges.
// - Disabling keeps clock mode reading old value until acknowledged.
// - Prescale divides selected clock by two to the field value.
// - Reset clears the counter.
// - Any counter write clears the counter, ignoring the data.
// - Debug halts the counter unless run-in-debug is set.
// - Counter reads take two extra wait states.
// - Unused upper bits of status and counter read as zero.
// - Sixteen-bit modulo held in low bits, upper bits zero.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_status_counter
    import pwm_timer_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Timer pins and debug
    input wire logic external_clock_input,
    input wire logic debug_active,
    input wire logic run_in_debug,
    // Outputs to channels, DMA and interrupt controller
    output logic [15:0] counter_out,
    output logic count_down,
    output logic dma_request,
    output logic irq
);
    typedef enum logic [2:0] {
        bus_idle = 3'h1,
        bus_wait = 3'h2,
        bus_done = 3'h4
    } bus_state_t;

    typedef struct packed {
        bus_state_t bus;
        logic [1:0] waits;
        logic [31:0] rdata;
        logic wreq;
        logic waitreq;
        timer_ctrl_t ctrl;
        logic [1:0] mode_shown;
        logic overflow_flag;
        logic [15:0] modulo;
        logic [15:0] count;
        logic down;
        logic dma_req;
        logic irq;
        logic ovf_irq_status;
        logic ovf_irq_mask;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;
    logic [1:0] rst_sync;
    logic rst_n;
    logic ext_rise;
    logic src_tick;
    logic tick;
    logic enabled;
    logic overflow;
    logic wr_take;
    logic rd_take;
    logic [31:0] status_view;

    // Checks sample on the timer clock and rest while reset is held
    default clocking check_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Reset released through two flip-flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ext_clock_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .external_clock_input(external_clock_input),
        .rise(ext_rise)
    );

    // Source select; reserved mode 11 counts nothing
    assign enabled = (state.ctrl.clock_mode == clock_mode_internal) ||
                     (state.ctrl.clock_mode == clock_mode_external);
    assign src_tick = (state.ctrl.clock_mode == clock_mode_internal) |
        ((state.ctrl.clock_mode == clock_mode_external) & ext_rise);

    prescaler u_presc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(enabled),
        .source_tick(src_tick),
        .prescale(state.ctrl.prescale),
        .tick(tick)
    );

    // Overflow when counting up from the modulo value
    assign overflow = tick & ~(debug_active & ~run_in_debug) & ~state.down &
                      (state.count == state.modulo);

    // Status/control read view, upper bits zero
    always_comb begin
        status_view = 32'h0000_0000;
        status_view[dma_enable_bit] = state.ctrl.dma_enable;
        status_view[overflow_flag_bit] = state.overflow_flag;
        status_view[overflow_irq_enable_bit] = state.ctrl.overflow_irq_enable;
        status_view[center_aligned_bit] = state.ctrl.center_aligned;
        status_view[clock_mode_lsb +: 2] = state.mode_shown;
        status_view[prescale_lsb +: 3] = state.ctrl.prescale;
    end

    assign wr_take = (state.bus == bus_done) & state.wreq;
    assign rd_take = (state.bus == bus_done) & ~state.wreq;

    // Bus handshake, register updates and counter
    always_comb begin
        next_state = state;
        // Bus sequencing: one cycle for most, two more for counter reads
        case (state.bus)
            bus_idle: begin
                if (read || write) begin
                    next_state.wreq = write;
                    next_state.waits = 2'h0;
                    if (read && address == counter_offset) begin
                        next_state.bus = bus_wait;
                    end else begin
                        next_state.bus = bus_done;
                    end
                end
            end
            bus_wait: begin
                // Time for the counter value to settle over the crossing
                next_state.waits = state.waits + 2'h1;
                if (state.waits == counter_read_waits - 2'h1) begin
                    next_state.bus = bus_done;
                end
            end
            bus_done: begin
                next_state.bus = bus_idle;
            end
            default: begin
                next_state.bus = bus_idle;
            end
        endcase
        // Registered so the bus sees no decode glitch on waitrequest
        next_state.waitreq = (next_state.bus != bus_done);
        // Read data is latched on the same edge that waitrequest falls
        if (next_state.bus == bus_done && !next_state.wreq) begin
            case (address)
                status_control_offset: next_state.rdata = status_view;
                counter_offset: next_state.rdata = {16'h0000, state.count};
                modulo_offset: next_state.rdata = {16'h0000, state.modulo};
                irq_status_offset: next_state.rdata =
                    {30'h0, state.ovf_irq_mask, state.ovf_irq_status};
                default: next_state.rdata = 32'h0000_0000;
            endcase
        end
        // Disable acknowledged in the counting logic one cycle later
        next_state.mode_shown = state.ctrl.clock_mode;
        // Counting
        if (tick && !(debug_active && !run_in_debug)) begin
            if (!state.ctrl.center_aligned) begin
                next_state.down = 1'b0;
                if (state.count == state.modulo) begin
                    next_state.count = 16'h0000;
                end else begin
                    next_state.count = state.count + 16'h0001;
                end
            end else if (!state.down) begin
                if (state.count >= state.modulo) begin
                    next_state.down = 1'b1;
                    next_state.count = state.count - 16'h0001;
                end else begin
                    next_state.count = state.count + 16'h0001;
                end
            end else begin
                if (state.count == 16'h0000) begin
                    next_state.down = 1'b0;
                    next_state.count = 16'h0001;
                end else begin
                    next_state.count = state.count - 16'h0001;
                end
            end
        end
        // Register writes
        if (wr_take) begin
            case (address)
                status_control_offset: begin
                    next_state.ctrl.dma_enable = writedata[dma_enable_bit];
                    next_state.ctrl.overflow_irq_enable =
                        writedata[overflow_irq_enable_bit];
                    next_state.ctrl.clock_mode =
                        writedata[clock_mode_lsb +: 2];
                    if (!enabled) begin
                        next_state.ctrl.center_aligned =
                            writedata[center_aligned_bit];
                        next_state.ctrl.prescale =
                            writedata[prescale_lsb +: 3];
                    end
                    if (writedata[overflow_flag_bit]) begin
                        next_state.overflow_flag = 1'b0;
                    end
                end
                counter_offset: begin
                    next_state.count = 16'h0000;
                    next_state.down = 1'b0;
                end
                modulo_offset: next_state.modulo = writedata[15:0];
                irq_status_offset: begin
                    if (writedata[0]) begin
                        next_state.ovf_irq_status = 1'b0;
                    end
                    next_state.ovf_irq_mask = writedata[1];
                end
                default: begin
                end
            endcase
        end
        // Set wins over a clear landing in the same cycle
        if (overflow) begin
            next_state.overflow_flag = 1'b1;
            next_state.ovf_irq_status = 1'b1;
        end
        next_state.dma_req = next_state.overflow_flag &
                             next_state.ctrl.dma_enable;
        next_state.irq = (next_state.overflow_flag &
                          next_state.ctrl.overflow_irq_enable) |
                         (next_state.ovf_irq_status &
                          next_state.ovf_irq_mask);
    end

    // Register the state; reset clears the counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.bus <= bus_idle;
            state.modulo <= modulo_reset;
            state.waitreq <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign readdata = state.rdata;
    assign waitrequest = state.waitreq;
    assign counter_out = state.count;
    assign count_down = state.down;
    assign dma_request = state.dma_req;
    assign irq = state.irq;

    // Checks: flag set, clear and hold
    overflow_sets_a: assert property (
        overflow |=> state.overflow_flag)
        else $error("overflow did not set flag");
    clear_flag_a: assert property (
        (wr_take && address == status_control_offset &&
         writedata[overflow_flag_bit] && !overflow)
        |=> !state.overflow_flag)
        else $error("flag not cleared");
    keep_flag_a: assert property (
        (state.overflow_flag && !wr_take) |=> state.overflow_flag)
        else $error("flag lost without write");
    // Checks: counter writes, halts, wrap and direction
    counter_clear_a: assert property (
        (wr_take && address == counter_offset) |=> state.count == 16'h0000)
        else $error("counter write did not clear");
    debug_hold_a: assert property (
        (debug_active && !run_in_debug && !wr_take) |=> $stable(state.count))
        else $error("counter moved in debug");
    stopped_hold_a: assert property (
        (!enabled && !wr_take) |=> $stable(state.count))
        else $error("counter moved while stopped");
    wrap_up_a: assert property (
        (overflow && !state.ctrl.center_aligned && !wr_take)
        |=> state.count == 16'h0000)
        else $error("up counter did not wrap");
    up_only_a: assert property (
        (!state.ctrl.center_aligned && !state.down) |=> !state.down)
        else $error("down count without center-aligned select");
    // Undivided external edges each move the counter by one
    ext_count_a: assert property (
        (state.ctrl.clock_mode == clock_mode_external && ext_rise &&
         state.ctrl.prescale == 3'h0 && !state.ctrl.center_aligned &&
         !(debug_active && !run_in_debug) && !wr_take &&
         state.count != state.modulo)
        |=> state.count == $past(state.count) + 16'h0001)
        else $error("external edge not counted");
    // Checks: bus timing, protection and read view
    read_waits_a: assert property (
        (state.bus == bus_idle && read && address == counter_offset)
        |=> waitrequest [*2] ##1 !waitrequest)
        else $error("counter read wait states wrong");
    protect_cfg_a: assert property (
        enabled |=> $stable(state.ctrl.prescale) &&
        $stable(state.ctrl.center_aligned))
        else $error("protected field changed while enabled");
    mode_lag_a: assert property (
        (wr_take && address == status_control_offset)
        |=> state.mode_shown == $past(state.ctrl.clock_mode))
        else $error("clock mode shown without lag");
    upper_zero_a: assert property (
        (!waitrequest && !state.wreq) |-> readdata[31:16] == 16'h0000 &&
        (address != status_control_offset || readdata[15:9] == 7'h00))
        else $error("reserved bits set");
    // Checks: interrupt and DMA levels
    irq_level_a: assert property (
        (state.overflow_flag && state.ctrl.overflow_irq_enable) |-> irq)
        else $error("interrupt missing");
    dma_level_a: assert property (
        dma_request == (state.overflow_flag && state.ctrl.dma_enable))
        else $error("dma request mismatch");
    // Main scenarios that the bench should reach
    cover_overflow_c: cover property (overflow);
    cover_updown_c: cover property (
        state.ctrl.center_aligned && $rose(state.down));
    cover_clash_c: cover property (overflow && wr_take);
    cover_external_c: cover property (src_tick && ext_rise);
endmodule
`default_nettype wire

// ===== design/pwm_timer_pkg.sv
// Package: register map, field layout, reset values and types of the timer
`default_nettype none
package pwm_timer_pkg;
    // Register byte offsets
    localparam logic [3:0] status_control_offset = 4'h0;
    localparam logic [3:0] counter_offset = 4'h4;
    localparam logic [3:0] modulo_offset = 4'h8;
    localparam logic [3:0] irq_status_offset = 4'hC;
    // Status/control field positions
    localparam int dma_enable_bit = 8;
    localparam int overflow_flag_bit = 7;
    localparam int overflow_irq_enable_bit = 6;
    localparam int center_aligned_bit = 5;
    localparam int clock_mode_lsb = 3;
    localparam int prescale_lsb = 0;
    // Clock mode codes
    localparam logic [1:0] clock_mode_off = 2'h0;
    localparam logic [1:0] clock_mode_internal = 2'h1;
    localparam logic [1:0] clock_mode_external = 2'h2;
    // Reset values
    localparam logic [15:0] modulo_reset = 16'hFFFF;
    // Extra wait states on a counter read
    localparam logic [1:0] counter_read_waits = 2'h2;

    // Software-visible control settings
    typedef struct packed {
        logic dma_enable;
        logic overflow_irq_enable;
        logic center_aligned;
        logic [1:0] clock_mode;
        logic [2:0] prescale;
    } timer_ctrl_t;

    // Avalon-MM slave request
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avalon_req_t;
endpackage
`default_nettype wire

// ===== design/ext_clock_sync.sv
// Three-stage synchroniser and rising edge detector for the external clock
`timescale 1ns/1ps
`default_nettype none
module ext_clock_sync
    import pwm_timer_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Pin and edge pulse
    input wire logic external_clock_input,
    output logic rise
);
    typedef struct packed {
        logic [2:0] stages;
        logic rise;
    } sync_state_t;
    sync_state_t state;
    sync_state_t next_state;

    // Edge counts when the second stage is high while the third is still low
    always_comb begin
        next_state = state;
        next_state.stages = {state.stages[1:0], external_clock_input};
        next_state.rise = state.stages[1] & ~state.stages[2];
    end

    // Register the state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rise = state.rise;
endmodule
`default_nettype wire

// ===== design/prescaler.sv
// Power-of-two prescaler producing a count tick
`timescale 1ns/1ps
`default_nettype none
module prescaler
    import pwm_timer_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic source_tick,
    input wire logic [2:0] prescale,
    // Output tick
    output logic tick
);
    typedef struct packed {
        logic [6:0] count;
    } presc_state_t;
    presc_state_t state;
    presc_state_t next_state;
    logic [6:0] limit;

    // Divider restarts when disabled so a full period follows enabling
    always_comb begin
        next_state = state;
        limit = 7'((8'h01 << prescale) - 8'h01);
        tick = 1'b0;
        if (!enable) begin
            next_state.count = 7'h00;
        end else if (source_tick) begin
            if (state.count >= limit) begin
                next_state.count = 7'h00;
                tick = 1'b1;
            end else begin
                next_state.count = state.count + 7'h01;
            end
        end
    end

    // Register the state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // A stopped counter must restart with a whole prescaled period
    restart_a: assert property (@(posedge ref_clk)
        disable iff (!rst_n) !enable |=> state.count == 7'h00)
        else $error("prescaler kept its phase while stopped");
endmodule
`default_nettype wire

// ===== test/pwm_timer_status_counter_tb.sv
// Self-checking bench for the timer status, modulo and counter block
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_status_counter_tb;
    import pwm_timer_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    avalon_req_t req = '0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [15:0] counter_out;
    logic count_down;
    logic dma_request;
    logic irq;
    logic external_clock_input = 1'b0;
    logic debug_active = 1'b0;
    logic run_in_debug = 1'b0;
    logic [31:0] rnd = 32'h31679EE2;
    logic [31:0] rd;
    logic [15:0] m_modulo = 16'hFFFF;
    logic [15:0] c0;
    int n_fail = 0;
    int checks = 0;
    int wait_n;
    int n0;
    int g;

    pwm_timer_status_counter pwm_timer_status_counter_inst (
        .ref_clk(ref_clk), .nrst(nrst), .address(req.address),
        .read(req.read), .write(req.write), .writedata(req.writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .external_clock_input(external_clock_input),
        .debug_active(debug_active), .run_in_debug(run_in_debug),
        .counter_out(counter_out), .count_down(count_down),
        .dma_request(dma_request), .irq(irq)
    );

    // Free-running 20 MHz clock
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // Comparison helpers; four-state equality so unknowns never match
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: pin %b want %b", $time, got, exp);
        end
    endtask

    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic [3:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        req <= '{address: a, read: !w, write: w, writedata: d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0) begin
            n_fail++;
            $display("unexpected at %0t: bus never answered", $time);
        end
        rd = readdata;
        wait_n = n;
        req <= '0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk_reg(rd, exp);
    endtask

    // Disable, wait until the mode field reads zero, then clear controls
    task automatic stop();
        int k;
        wr(status_control_offset, 32'h0);
        k = 0;
        do begin
            bus(status_control_offset, 1'b0, 32'h0);
            k++;
        end while (rd[4:3] !== 2'b00 && k < 8);
        chk_reg({30'h0, rd[4:3]}, 32'h0);
        wr(status_control_offset, 32'h0);
    endtask

    // Cycles until the count next moves, giving up after 300
    task automatic gap(output int n);
        logic [15:0] c;
        n = 0;
        c = counter_out;
        do begin
            @(posedge ref_clk);
            n++;
        end while (counter_out === c && n < 300);
    endtask

    // Reference counter: predicts each step and direction at any prescale
    task automatic follow(input int n, input bit ud);
        logic [15:0] c;
        logic [15:0] p;
        logic [15:0] e;
        p = counter_out;
        gap(g);
        for (int i = 0; i < n; i++) begin
            c = counter_out;
            gap(g);
            if (!ud) e = (c == m_modulo) ? 16'h0 : c + 16'h1;
            else if (c == m_modulo) e = c - 16'h1;
            else if (c == 16'h0) e = 16'h1;
            else e = (c < p) ? c - 16'h1 : c + 16'h1;
            chk_reg({16'h0, counter_out}, {16'h0, e});
            chk_pin(count_down, ud && e < c);
            p = c;
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        $display("unexpected at %0t: run timed out", $time);
        results();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rdc(counter_offset, 32'h0);
        rdc(modulo_offset, 32'h0000FFFF);
        rdc(status_control_offset, 32'h0);
        n0 = wait_n;
        wr(status_control_offset, 32'hFFFFFFFF);
        rdc(status_control_offset, 32'h0000017F);
        repeat (5) @(posedge ref_clk);
        chk_reg({16'h0, counter_out}, 32'h0);
        wr(modulo_offset, 32'hFFFFFFFF);
        rdc(modulo_offset, 32'h0000FFFF);
        wr(4'h1, 32'hFFFFFFFF);
        rdc(4'h1, 32'h0);
        stop();
        $display("test reset and map finished");
        // Each prescale code, counter cleared by a random write first
        for (int p = 0; p < 8; p++) begin
            stop();
            rnd = xs(rnd);
            wr(counter_offset, rnd);
            rdc(counter_offset, 32'h0);
            wr(status_control_offset, 32'h8 | p);
            gap(g);
            c0 = counter_out;
            gap(g);
            chk_reg(32'(g), 32'h1 << p);
            chk_reg({16'h0, counter_out}, {16'h0, c0 + 16'h1});
        end
        wr(status_control_offset, 32'h28);
        rdc(status_control_offset, 32'h0000000F);
        $display("test prescale finished");
        // Overflow in up mode with interrupt, DMA and masked status
        stop();
        m_modulo = 16'h3;
        wr(modulo_offset, 32'h3);
        wr(counter_offset, 32'h0);
        wr(irq_status_offset, 32'h2);
        wr(status_control_offset, 32'h149);
        follow(12, 1'b0);
        chk_pin(irq, 1'b1);
        chk_pin(dma_request, 1'b1);
        rdc(status_control_offset, 32'h000001C9);
        stop();
        rdc(status_control_offset, 32'h00000080);
        chk_pin(dma_request, 1'b0);
        chk_pin(irq, 1'b1);
        wr(irq_status_offset, 32'h0);
        chk_pin(irq, 1'b0);
        rdc(irq_status_offset, 32'h1);
        wr(irq_status_offset, 32'h1);
        rdc(irq_status_offset, 32'h0);
        wr(status_control_offset, 32'h80);
        rdc(status_control_offset, 32'h0);
        $display("test overflow finished");
        // Modulo zero overflows every tick, so a clear cannot win
        m_modulo = 16'h0;
        wr(modulo_offset, 32'h0);
        wr(counter_offset, 32'h0);
        wr(status_control_offset, 32'h8);
        repeat (4) @(posedge ref_clk);
        wr(status_control_offset, 32'h88);
        rdc(status_control_offset, 32'h00000088);
        $display("test clear race finished");
        // Up-down counting
        stop();
        m_modulo = 16'h4;
        wr(modulo_offset, 32'h4);
        wr(counter_offset, 32'h0);
        wr(status_control_offset, 32'h28);
        follow(20, 1'b1);
        $display("test up-down finished");
        // Debug halt and run-in-debug
        stop();
        m_modulo = 16'hFFFF;
        wr(modulo_offset, 32'hFFFF);
        wr(status_control_offset, 32'h8);
        debug_active <= 1'b1;
        repeat (3) @(posedge ref_clk);
        c0 = counter_out;
        repeat (10) @(posedge ref_clk);
        chk_reg({16'h0, counter_out}, {16'h0, c0});
        run_in_debug <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk_pin(counter_out !== c0, 1'b1);
        debug_active <= 1'b0;
        run_in_debug <= 1'b0;
        $display("test debug finished");
        // External clock edges at random spacing
        stop();
        wr(counter_offset, 32'h0);
        wr(status_control_offset, 32'h10);
        for (int i = 0; i < 10; i++) begin
            rnd = xs(rnd);
            external_clock_input <= 1'b1;
            repeat (3 + rnd[2:0]) @(posedge ref_clk);
            external_clock_input <= 1'b0;
            repeat (3 + rnd[5:3]) @(posedge ref_clk);
        end
        repeat (6) @(posedge ref_clk);
        rdc(counter_offset, 32'hA);
        chk_reg(32'(wait_n), 32'(n0 + 2));
        $display("test external clock finished");
        results();
    end
endmodule
`default_nettype wire
